/* File: hw/byte_move_pkg.sv */
// shared types and constants of the byte move datapath
package byte_move_pkg;

  localparam int WORD_W = 16;
  localparam int ACC_W = 32;
  localparam int RPT_W = 16;

  // accumulator half boundaries and byte lanes of a word
  localparam int HALF_LO_BIT = 0;
  localparam int HALF_HI_BIT = 16;
  localparam int LANE_HI_BIT = 8;
  localparam int SIGN_BIT = 15;

  // reset values
  localparam logic [ACC_W-1:0] ACC_RST = 32'h0000_0000;
  localparam logic [RPT_W-1:0] RPT_RST = 16'h0000;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [WORD_W-1:0] ZERO_WORD = 16'h0000;

  // condition codes
  localparam logic [3:0] CC_NEQ = 4'h0;
  localparam logic [3:0] CC_EQ = 4'h1;
  localparam logic [3:0] CC_GT = 4'h2;
  localparam logic [3:0] CC_GEQ = 4'h3;
  localparam logic [3:0] CC_LT = 4'h4;
  localparam logic [3:0] CC_LEQ = 4'h5;
  localparam logic [3:0] CC_HI = 4'h6;
  localparam logic [3:0] CC_HIS = 4'h7;
  localparam logic [3:0] CC_LO = 4'h8;
  localparam logic [3:0] CC_LOS = 4'h9;
  localparam logic [3:0] CC_NOV = 4'ha;
  localparam logic [3:0] CC_OV = 4'hb;
  localparam logic [3:0] CC_NTC = 4'hc;
  localparam logic [3:0] CC_TC = 4'hd;
  localparam logic [3:0] CC_NBIO = 4'he;
  localparam logic [3:0] CC_UNC = 4'hf;

  typedef enum logic [1:0] {
    OP_LOAD_LOW  = 2'h0,
    OP_LOAD_HIGH = 2'h1,
    OP_STORE     = 2'h2,
    OP_CONDITION_CODE      = 2'h3
  } byte_move_op_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_READ = 2'b10
  } state_t;

  typedef struct packed {
    byte_move_op_t op;
    logic acc_half_sel;
    logic [3:0] condition_code;
    logic [7:0] imm8;
    logic parity_mode;
    logic offset_odd;
    logic operand_is_acc;
    logic operand_half;
    logic [WORD_W-1:0] addr;
  } byte_req_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
    logic v;
    logic tc;
    logic branch_input_pin;
  } condition_code_flags_t;

endpackage

/* File: hw/condition_eval.sv */
// evaluates a 4-bit condition code against the status flags
`timescale 1ns/1ps
module condition_eval
  import byte_move_pkg::*;
(
  input wire logic [3:0] condition_code_i,
  input wire condition_code_flags_t flags_i,
  output logic condition_code_true_o,
  output logic tests_v_o
);

  always_comb begin
    unique case (condition_code_i)
      CC_NEQ: condition_code_true_o = !flags_i.z;
      CC_EQ: condition_code_true_o = flags_i.z;
      CC_GT: condition_code_true_o = !flags_i.z && !flags_i.n;
      CC_GEQ: condition_code_true_o = !flags_i.n;
      CC_LT: condition_code_true_o = flags_i.n;
      CC_LEQ: condition_code_true_o = flags_i.z || flags_i.n;
      CC_HI: condition_code_true_o = flags_i.c && !flags_i.z;
      CC_HIS: condition_code_true_o = flags_i.c;
      CC_LO: condition_code_true_o = !flags_i.c;
      CC_LOS: condition_code_true_o = !flags_i.c || flags_i.z;
      CC_NOV: condition_code_true_o = !flags_i.v;
      CC_OV: condition_code_true_o = flags_i.v;
      CC_NTC: condition_code_true_o = !flags_i.tc;
      CC_TC: condition_code_true_o = flags_i.tc;
      CC_NBIO: condition_code_true_o = !flags_i.branch_input_pin;
      CC_UNC: condition_code_true_o = 1'b1;
    endcase
  end

  // overflow-testing codes clear the overflow flag
  assign tests_v_o = (condition_code_i == CC_NOV) ||
                     (condition_code_i == CC_OV);

endmodule

/* File: hw/byte_move_datapath.sv */
// byte load, byte store and conditional constant store datapath
`timescale 1ns/1ps

// How it works
// - low-byte load puts selected byte in bits 7..0, clears bits 15..8
// - indexed forms pick low byte for even offset, high byte for odd
// - parity pick only for 3-bit immediate or aux index zero/one forms
// - high-byte load writes bits 15..8 and keeps bits 7..0
// - after byte loads N is bit 15 and Z flags a zero half
// - byte ops are never repeated; they clear the repeat counter unless a repeat load comes in the same cycle
// - conditional store writes zero-extended constant only when true
// - codes 0..5 test zero and negative flags
// - codes 6..9 test carry and zero flags
// - codes 10..15 test overflow, test bit, branch pin, or always
// - pointer modification happens whether or not condition holds
// - conditional store sets N and Z only if true and target is a half
// - codes testing overflow clear the overflow flag
// - byte store writes low byte of a half into selected byte lane
// - byte store reads, merges and writes back the whole word
// - byte store into an accumulator half updates N and Z
module byte_move_datapath
  import byte_move_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i,
  input wire byte_req_t op_req_i,
  input wire logic mem_rvalid_i,
  input wire logic [WORD_W-1:0] mem_rdata_i,
  input wire logic acc_wr_i,
  input wire logic [ACC_W-1:0] acc_wdata_i,
  input wire logic carry_flag_i,
  input wire logic test_bit_flag_i,
  input wire logic branch_input_pin_i,
  input wire logic overflow_set_i,
  input wire logic repeat_load_i,
  input wire logic [RPT_W-1:0] repeat_value_i,
  output logic busy_o,
  output logic done_o,
  output logic ptr_mod_o,
  output logic mem_rd_o,
  output logic mem_wr_o,
  output logic [WORD_W-1:0] mem_addr_o,
  output logic [WORD_W-1:0] mem_wdata_o,
  output logic [ACC_W-1:0] accumulator32_o,
  output logic flag_n_o,
  output logic flag_z_o,
  output logic flag_v_o,
  output logic [RPT_W-1:0] repeat_counter_o
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [7:0] pick_byte(input logic [WORD_W-1:0] w,
                                           input logic hi);
    pick_byte = hi ? w[LANE_HI_BIT +: 8] : w[HALF_LO_BIT +: 8];
  endfunction

  function automatic logic [WORD_W-1:0] merge_byte(
      input logic [WORD_W-1:0] w, input logic [7:0] b, input logic hi);
    merge_byte = hi ? {b, w[LANE_HI_BIT-1:0]} : {w[WORD_W-1:LANE_HI_BIT], b};
  endfunction

  function automatic logic [WORD_W-1:0] half_of(
      input logic [ACC_W-1:0] acc, input logic upper);
    half_of = upper ? acc[HALF_HI_BIT +: WORD_W] : acc[HALF_LO_BIT +: WORD_W];
  endfunction

  // one byte lane of one accumulator half, used by the checks
  function automatic logic [7:0] half_byte(input logic [ACC_W-1:0] acc,
      input logic upper, input logic hi);
    half_byte = pick_byte(half_of(acc, upper), hi);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // request selection and result computation

  state_t state;
  byte_req_t req_q;
  byte_req_t src;
  logic accept;
  logic finish;
  logic hi_lane;
  logic [WORD_W-1:0] word;
  logic [7:0] sel_byte;
  logic [WORD_W-1:0] src_half;
  logic [WORD_W-1:0] result;
  logic result_half;
  logic acc_we;
  logic mem_we;
  logic condition_code_true;
  logic tests_v;
  logic v_clear;
  condition_code_flags_t flags;

  assign accept = op_valid_i && (state == ST_IDLE);
  assign src = (state == ST_IDLE) ? op_req_i : req_q;
  // operand word comes from the accumulator half or from memory
  assign word = (state == ST_IDLE) ?
                half_of(accumulator32_o, src.operand_half) : mem_rdata_i;
  assign finish = (accept && (src.operand_is_acc || src.op == OP_CONDITION_CODE)) ||
                  ((state == ST_READ) && mem_rvalid_i);
  assign hi_lane = src.parity_mode && src.offset_odd;
  assign sel_byte = pick_byte(word, hi_lane);
  assign src_half = half_of(accumulator32_o, src.acc_half_sel);

  assign flags = '{n: flag_n_o, z: flag_z_o, c: carry_flag_i, v: flag_v_o,
                   tc: test_bit_flag_i, branch_input_pin: branch_input_pin_i};

  condition_eval u_condition_code (
    .condition_code_i(src.condition_code),
    .flags_i(flags),
    .condition_code_true_o(condition_code_true),
    .tests_v_o(tests_v)
  );

  always_comb begin
    result = ZERO_WORD;
    result_half = src.operand_half;
    unique case (src.op)
      OP_LOAD_LOW: begin
        result = {ZERO_BYTE, sel_byte};
        result_half = src.acc_half_sel;
      end
      OP_LOAD_HIGH: begin
        result = {sel_byte, src_half[7:0]};
        result_half = src.acc_half_sel;
      end
      OP_STORE: begin
        result = merge_byte(word, src_half[7:0], hi_lane);
      end
      OP_CONDITION_CODE: result = {ZERO_BYTE, src.imm8};
    endcase
  end

  assign acc_we = finish &&
                  ((src.op == OP_LOAD_LOW) || (src.op == OP_LOAD_HIGH) ||
                   (src.operand_is_acc &&
                    ((src.op == OP_STORE) || condition_code_true)));
  assign mem_we = finish && !src.operand_is_acc &&
                  ((src.op == OP_STORE) ||
                   ((src.op == OP_CONDITION_CODE) && condition_code_true));
  assign v_clear = finish && (src.op == OP_CONDITION_CODE) && tests_v;

  ////////////////////////////////////////////////////////////////////////
  // sequencing

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      unique case (state)
        ST_IDLE: if (accept && !finish) state <= ST_READ;
        ST_READ: if (mem_rvalid_i) state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      req_q <= '0;
    end else if (accept) begin
      req_q <= op_req_i;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_o <= 1'b0;
      done_o <= 1'b0;
      ptr_mod_o <= 1'b0;
    end else begin
      busy_o <= (accept && !finish) || ((state == ST_READ) && !mem_rvalid_i);
      done_o <= finish;
      ptr_mod_o <= accept;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // memory side

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mem_rd_o <= 1'b0;
      mem_wr_o <= 1'b0;
      mem_addr_o <= ZERO_WORD;
      mem_wdata_o <= ZERO_WORD;
    end else begin
      mem_rd_o <= accept && !finish;
      mem_wr_o <= mem_we;
      if (accept) begin
        mem_addr_o <= op_req_i.addr;
      end
      if (mem_we) begin
        mem_wdata_o <= result;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // accumulator and flags

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      accumulator32_o <= ACC_RST;
    end else if (acc_we) begin
      if (result_half) begin
        accumulator32_o[HALF_HI_BIT +: WORD_W] <= result;
      end else begin
        accumulator32_o[HALF_LO_BIT +: WORD_W] <= result;
      end
    end else if (acc_wr_i) begin
      accumulator32_o <= acc_wdata_i;
    end
  end

  // flags follow any half written by an operation here; acc_wr_i loads leave them unchanged
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_n_o <= 1'b0;
      flag_z_o <= 1'b0;
    end else if (acc_we) begin
      flag_n_o <= result[SIGN_BIT];
      flag_z_o <= (result == ZERO_WORD);
    end
  end

  // a new overflow event wins over the clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flag_v_o <= 1'b0;
    end else if (overflow_set_i) begin
      flag_v_o <= 1'b1;
    end else if (v_clear) begin
      flag_v_o <= 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      repeat_counter_o <= RPT_RST;
    end else if (repeat_load_i) begin
      repeat_counter_o <= repeat_value_i;
    end else if (accept) begin
      repeat_counter_o <= RPT_RST;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_n_i);

  chk_low_load_clear: assert property (
    finish && src.op == OP_LOAD_LOW |=>
      half_byte(accumulator32_o, $past(src.acc_half_sel), 1'b1) ==
      ZERO_BYTE)
    else $error("low byte load left upper byte set");

  chk_odd_lane_pick: assert property (
    finish && src.op == OP_LOAD_LOW && src.parity_mode && src.offset_odd |=>
      half_byte(accumulator32_o, $past(src.acc_half_sel), 1'b0) ==
      $past(word[15:8]))
    else $error("odd offset did not pick high byte");

  chk_plain_lane_low: assert property (
    finish && src.op == OP_LOAD_LOW && !src.parity_mode |=>
      half_byte(accumulator32_o, $past(src.acc_half_sel), 1'b0) ==
      $past(word[7:0]))
    else $error("non-indexed form did not pick low byte");

  chk_high_keeps_low: assert property (
    finish && src.op == OP_LOAD_HIGH |=>
      half_byte(accumulator32_o, $past(src.acc_half_sel), 1'b0) ==
      $past(src_half[7:0]))
    else $error("high byte load disturbed low byte");

  chk_flags_follow: assert property (
    acc_we |=> flag_n_o == $past(result[15]) &&
               flag_z_o == ($past(result) == ZERO_WORD))
    else $error("n or z flag does not match written half");

  chk_repeat_cleared: assert property (
    accept && !repeat_load_i |=> repeat_counter_o == RPT_RST)
    else $error("repeat counter survived a byte op");

  chk_false_no_write: assert property (
    finish && src.op == OP_CONDITION_CODE && !condition_code_true |=>
      !mem_wr_o && $stable(accumulator32_o) ##1 !mem_wr_o)
    else $error("false condition touched the target");

  chk_ptr_always_mod: assert property (
    accept |=> ptr_mod_o)
    else $error("pointer update skipped");

  chk_v_clear_test: assert property (
    finish && src.op == OP_CONDITION_CODE && src.condition_code[3:1] == 3'h5 &&
    !overflow_set_i |=> !flag_v_o)
    else $error("overflow flag not cleared by test");

  chk_rmw_sequence: assert property (
    accept && src.op == OP_STORE && !src.operand_is_acc |=>
      mem_rd_o ##0 (!mem_wr_o throughout (busy_o [*1])))
    else $error("byte store did not start with a read");

  chk_merge_keeps: assert property (
    state == ST_READ && mem_rvalid_i && src.op == OP_STORE && !hi_lane |=>
      mem_wr_o && mem_wdata_o[15:8] == $past(mem_rdata_i[15:8]))
    else $error("byte store disturbed the other byte");

  chk_unc_true: assert property (
    finish && src.op == OP_CONDITION_CODE && src.condition_code == CC_UNC &&
    !src.operand_is_acc |=> mem_wr_o)
    else $error("unconditional store did not write");

  cov_load_high: cover property (finish && src.op == OP_LOAD_HIGH);
  cov_store_odd: cover property (mem_we && src.op == OP_STORE && hi_lane);
  cov_condition_code_false: cover property (finish && src.op == OP_CONDITION_CODE && !condition_code_true);
  cov_acc_target: cover property (acc_we && src.op == OP_STORE);

endmodule

/* File: verif/data_mem_model.sv */
// data memory model that answers word reads after a settable delay
`timescale 1ns/1ps
module data_mem_model
  import byte_move_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [3:0] delay_i,
  input wire logic mem_rd_i,
  input wire logic mem_wr_i,
  input wire logic [WORD_W-1:0] mem_addr_i,
  input wire logic [WORD_W-1:0] mem_wdata_i,
  output logic mem_rvalid_o,
  output logic [WORD_W-1:0] mem_rdata_o
);
  logic [WORD_W-1:0] mem [16];
  logic pend;
  logic [3:0] cnt;
  logic [3:0] addr_q;

  initial begin
    for (int i = 0; i < 16; i++) begin
      mem[i] = 16'(i * 16'h1f01);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pend <= 1'b0;
      cnt <= 4'h0;
      addr_q <= 4'h0;
      mem_rvalid_o <= 1'b0;
      mem_rdata_o <= 16'h0000;
    end else begin
      mem_rvalid_o <= 1'b0;
      // data lines are inverted every cycle outside the valid cycle, so the stale word returns every second cycle
      mem_rdata_o <= ~mem_rdata_o;
      if (mem_rd_i) begin
        pend <= 1'b1;
        cnt <= delay_i;
        addr_q <= mem_addr_i[3:0];
      end else if (pend && cnt != 4'h0) begin
        cnt <= cnt - 4'h1;
      end else if (pend) begin
        pend <= 1'b0;
        mem_rvalid_o <= 1'b1;
        mem_rdata_o <= mem[addr_q];
      end
      if (mem_wr_i) begin
        mem[mem_addr_i[3:0]] <= mem_wdata_i;
      end
    end
  end
endmodule

/* File: verif/byte_move_datapath_tb.sv */
// self-checking bench of the byte move datapath
`timescale 1ns/1ps
module byte_move_datapath_tb
  import byte_move_pkg::*;
;
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  byte_req_t op_req_i = '0;
  logic mem_rvalid_i;
  logic [WORD_W-1:0] mem_rdata_i;
  logic acc_wr_i = 1'b0;
  logic [ACC_W-1:0] acc_wdata_i = 32'h0000_0000;
  logic carry_flag_i = 1'b1;
  logic test_bit_flag_i = 1'b0;
  logic branch_input_pin_i = 1'b0;
  logic overflow_set_i = 1'b0;
  logic repeat_load_i = 1'b0;
  logic [RPT_W-1:0] repeat_value_i = 16'h0000;
  logic [3:0] dly = 4'h0;
  logic busy_o, done_o, ptr_mod_o, mem_rd_o, mem_wr_o;
  logic [WORD_W-1:0] mem_addr_o, mem_wdata_o;
  logic [ACC_W-1:0] accumulator32_o;
  logic flag_n_o, flag_z_o, flag_v_o;
  logic [RPT_W-1:0] repeat_counter_o;
  logic [31:0] exp_acc = 32'h0000_0000;
  logic exp_n = 1'b0;
  logic exp_z = 1'b0;
  int n_errors = 0;
  int total_checks = 0;
  int n_ops = 0;
  int n_ptr = 0;

  always #20 clk_i = ~clk_i;

  byte_move_datapath u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .op_valid_i(op_valid_i), .op_req_i(op_req_i),
    .mem_rvalid_i(mem_rvalid_i), .mem_rdata_i(mem_rdata_i),
    .acc_wr_i(acc_wr_i), .acc_wdata_i(acc_wdata_i),
    .carry_flag_i(carry_flag_i), .test_bit_flag_i(test_bit_flag_i),
    .branch_input_pin_i(branch_input_pin_i),
    .overflow_set_i(overflow_set_i), .repeat_load_i(repeat_load_i),
    .repeat_value_i(repeat_value_i), .busy_o(busy_o), .done_o(done_o),
    .ptr_mod_o(ptr_mod_o), .mem_rd_o(mem_rd_o), .mem_wr_o(mem_wr_o),
    .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o),
    .accumulator32_o(accumulator32_o), .flag_n_o(flag_n_o),
    .flag_z_o(flag_z_o), .flag_v_o(flag_v_o),
    .repeat_counter_o(repeat_counter_o));

  data_mem_model u_mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .delay_i(dly),
    .mem_rd_i(mem_rd_o), .mem_wr_i(mem_wr_o), .mem_addr_i(mem_addr_o),
    .mem_wdata_i(mem_wdata_o), .mem_rvalid_o(mem_rvalid_i),
    .mem_rdata_o(mem_rdata_i));

  always @(posedge clk_i) begin
    if (ptr_mod_o === 1'b1) begin
      n_ptr++;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic byte_req_t mk(input byte_move_op_t op,
      input logic sel, input logic [3:0] cc, input logic [7:0] imm,
      input logic par, odd, isacc, half, input logic [3:0] a);
    mk = '{op, sel, cc, imm, par, odd, isacc, half, {12'h000, a}};
  endfunction

  function automatic logic ct(input logic [3:0] c,
      input logic n, z, cy, v, tc, branch_input_pin);
    case (c)
      4'h0: ct = !z;
      4'h1: ct = z;
      4'h2: ct = !z && !n;
      4'h3: ct = !n;
      4'h4: ct = n;
      4'h5: ct = z || n;
      4'h6: ct = cy && !z;
      4'h7: ct = cy;
      4'h8: ct = !cy;
      4'h9: ct = !cy || z;
      4'ha: ct = !v;
      4'hb: ct = v;
      4'hc: ct = !tc;
      4'hd: ct = tc;
      4'he: ct = !branch_input_pin;
      default: ct = 1'b1;
    endcase
  endfunction

  // request held one edge, then wait for the completion pulse
  task automatic run_op(input byte_req_t r);
    int k;
    logic eb;
    k = 0;
    eb = (r.op != OP_CONDITION_CODE) && !r.operand_is_acc;
    @(negedge clk_i);
    op_valid_i = 1'b1;
    op_req_i = r;
    @(negedge clk_i);
    op_valid_i = 1'b0;
    n_ops++;
    // a read is outstanding only for memory operands
    chk("busy_o", {31'h0, eb}, {31'h0, busy_o});
    while (done_o !== 1'b1 && k < 50) begin
      @(negedge clk_i);
      k++;
    end
    chk("done_o", 32'h1, {31'h0, done_o});
    // the memory takes the write one edge after the completion pulse
    @(negedge clk_i);
  endtask

  task automatic chk_nz();
    chk("flag_nz", {30'h0, exp_n, exp_z}, {30'h0, flag_n_o, flag_z_o});
  endtask

  // expected half written, flags derived, then compared
  task automatic upd(input logic half, input logic [15:0] h);
    if (half) exp_acc[31:16] = h;
    else exp_acc[15:0] = h;
    exp_n = h[SIGN_BIT];
    exp_z = (h == 16'h0000);
    chk("acc", exp_acc, accumulator32_o);
    chk_nz();
  endtask

  task automatic do_load(input byte_move_op_t op, input logic sel, par,
      odd, input logic [3:0] a);
    logic [15:0] w, h;
    logic [7:0] b;
    w = u_mem.mem[a];
    b = (par && odd) ? w[15:8] : w[7:0];
    h = sel ? exp_acc[31:16] : exp_acc[15:0];
    h = (op == OP_LOAD_LOW) ? {8'h00, b} : {b, h[7:0]};
    run_op(mk(op, sel, 4'h0, 8'h00, par, odd, 1'b0, 1'b0, a));
    upd(sel, h);
  endtask

  task automatic do_store(input logic sel, par, odd, isacc, half,
      input logic [3:0] a);
    logic [15:0] w;
    logic [7:0] b;
    b = sel ? exp_acc[23:16] : exp_acc[7:0];
    w = isacc ? (half ? exp_acc[31:16] : exp_acc[15:0]) : u_mem.mem[a];
    if (par && odd) w[15:8] = b;
    else w[7:0] = b;
    run_op(mk(OP_STORE, sel, 4'h0, 8'h00, par, odd, isacc, half, a));
    if (isacc) upd(half, w);
    else chk("mem_store", {16'h0, w}, {16'h0, u_mem.mem[a]});
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    #(40 * 20000);
    n_errors++;
    end_sim();
  end

  initial begin
    logic [15:0] old;
    logic t;
    logic ev;
    repeat (16) @(negedge clk_i);
    rst_n_i = 1'b1;
    chk("acc_rst", ACC_RST, accumulator32_o);
    chk("flags_rst", 32'h0, {29'h0, flag_n_o, flag_z_o, flag_v_o});
    @(negedge clk_i);
    acc_wr_i = 1'b1;
    acc_wdata_i = 32'hffff_ffff;
    repeat_load_i = 1'b1;
    repeat_value_i = 16'h0007;
    @(negedge clk_i);
    acc_wr_i = 1'b0;
    repeat_load_i = 1'b0;
    exp_acc = 32'hffff_ffff;
    chk("repeat_load", 32'h7, {16'h0, repeat_counter_o});
    do_load(OP_LOAD_LOW, 1'b0, 1'b1, 1'b1, 4'h3);
    chk("repeat_clr", 32'h0, {16'h0, repeat_counter_o});
    dly = 4'h5;
    do_load(OP_LOAD_LOW, 1'b1, 1'b0, 1'b1, 4'h4);
    do_load(OP_LOAD_HIGH, 1'b1, 1'b1, 1'b0, 4'h5);
    do_load(OP_LOAD_LOW, 1'b0, 1'b0, 1'b0, 4'h0);
    do_store(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h9);
    dly = 4'h0;
    do_store(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 4'h2);
    do_store(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
    do_load(OP_LOAD_HIGH, 1'b0, 1'b1, 1'b1, 4'h6);
    for (int c = 0; c < 16; c++) begin
      @(negedge clk_i);
      overflow_set_i = 1'b1;
      @(negedge clk_i);
      overflow_set_i = 1'b0;
      old = u_mem.mem[c];
      t = ct(c[3:0], exp_n, exp_z, carry_flag_i, 1'b1, test_bit_flag_i,
        branch_input_pin_i);
      run_op(mk(OP_CONDITION_CODE, 1'b0, c[3:0], 8'(8'h30 + c), 1'b0, 1'b0, 1'b0,
        1'b0, c[3:0]));
      if (t) old = {8'h00, 8'(8'h30 + c)};
      ev = !(c == 10 || c == 11);
      chk("condition_code_mem", {16'h0, old}, {16'h0, u_mem.mem[c]});
      chk("flag_v", {31'h0, ev}, {31'h0, flag_v_o});
      chk_nz();
    end
    run_op(mk(OP_CONDITION_CODE, 1'b0, CC_UNC, 8'h00, 1'b0, 1'b0, 1'b1, 1'b1, 4'h0));
    upd(1'b1, 16'h0000);
    // zero flag is now set, so this store is false and keeps everything
    run_op(mk(OP_CONDITION_CODE, 1'b0, CC_NEQ, 8'h5a, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0));
    chk("acc_kept", exp_acc, accumulator32_o);
    chk_nz();
    @(negedge clk_i);
    chk("ptr_mod_count", n_ops, n_ptr);
    end_sim();
  end
endmodule
